// File: bench/rxb_ctrl_tb.sv
// Self-checking testbench for the error mask and buffer control registers
`default_nettype none
module rxb_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rxb_pkg::*;

  logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
  rxb_req_t req;
  rxb_mgr_t mgr;
  logic [7:0] rdata, cs_a = 8'h3c, cs_b = 8'hc3, rx_cs, wwd, buf_rdata;
  logic [6:0] err_event = '0;
  logic [4:0] byte_i = '0, win_ofs;
  logic [3:0] xreq = '0, go;
  logic [1:0] hold_mode = 2'b10, shm;
  logic rvalid, err_out, irq, hreq, emphasis_a = 1'b1, emphasis_b = 1'b0, emphasis;
  logic bws, fbp, baw, cp, upd, win_rd, win_wr, win_user, win_chan_b;
  logic upin_drv = 1'b0, upin, upin_o, upin_oe, olr = 1'b0, ilr = 1'b0;
  logic rx_ubit = 1'b0, ubuf_bit = 1'b0, tx_bit, tx_stb;
  logic last_user, last_chan_b, last_tx;
  logic [4:0] last_ofs;
  logic [7:0] last_wd;
  int error_cnt = 0, total_checks = 0, win_cnt = 0, stb_cnt = 0, wr_cnt = 0;

  always #2.5 clk = ~clk;
  // Pin wire: the device wins while it drives, else the bench's level
  assign upin = (upin_oe === 1'b1) ? upin_o : upin_drv;
  assign buf_rdata = {3'h5, win_ofs};

  rxb_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  rxb_ctrl dut (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .err_event(err_event), .hold_mode(hold_mode),
    .receiver_error_out(err_out), .err_irq(irq), .sample_hold_req(hreq),
    .sample_hold_mode(shm), .emphasis_a(emphasis_a), .emphasis_b(emphasis_b),
    .chan_status_a(cs_a), .chan_status_b(cs_b), .emphasis_pin(emphasis),
    .rx_chan_status(rx_cs),
    .buffer_window_select(bws), .first_bytes_protect(fbp), .buffer_access_width(baw),
    .channel_pick(cp), .user_pin_direction(upd), .user_bit_manager_mode(mgr),
    .cs_dte_req(xreq[3]), .cs_dte_byte(byte_i), .cs_eft_req(xreq[2]),
    .ub_dte_req(xreq[1]), .ub_eft_req(xreq[0]), .cs_dte_go(go[3]), .cs_eft_go(go[2]),
    .ub_dte_go(go[1]), .ub_eft_go(go[0]), .buf_rdata(buf_rdata), .win_rd(win_rd),
    .win_wr(win_wr), .win_ofs(win_ofs), .win_wdata(wwd), .win_user(win_user),
    .win_chan_b(win_chan_b), .user_pin_i(upin), .user_pin_o(upin_o),
    .user_pin_oe(upin_oe), .output_side_lr_clock(olr), .input_side_lr_clock(ilr),
    .rx_user_bit(rx_ubit), .ubuf_tx_bit(ubuf_bit), .tx_user_bit(tx_bit),
    .tx_user_strobe(tx_stb)
  );

  always @(posedge clk) begin
    if (win_rd === 1'b1) begin
      win_cnt <= win_cnt + 1;
      {last_user, last_chan_b, last_ofs} <= {win_user, win_chan_b, win_ofs};
    end
    if (tx_stb === 1'b1) begin
      stb_cnt <= stb_cnt + 1;
      last_tx <= tx_bit;
    end
    if (win_wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      last_wd <= wwd;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    logic ok;
    host.read(a, d, ok);
    chk({7'h0, ok}, 8'h01, "read answered");
    chk(d, exp, msg);
  endtask

  task automatic t_regs();
    rd(RXB_MASK_OFS, 8'h00, "mask after reset");
    rd(RXB_CSB_OFS, 8'h00, "status control after reset");
    rd(RXB_UBC_OFS, 8'h00, "user control after reset");
    chk({1'b0, bws, fbp, baw, cp, upd, mgr}, 8'h00, "settings after reset");
    host.write(RXB_MASK_OFS, 8'hff);
    host.write(RXB_CSB_OFS, 8'hff);
    host.write(RXB_UBC_OFS, 8'hff);
    rd(RXB_MASK_OFS, 8'h7f, "mask top bit");
    rd(RXB_CSB_OFS, 8'h3f, "status control reserved bits");
    rd(RXB_UBC_OFS, 8'h1f, "user control reserved bits");
    chk({1'b0, bws, fbp, baw, cp, upd, mgr}, 8'h7f, "settings all set");
    rd(7'h05, 8'h00, "unmapped read");
    clk_en = 1'b0;
    host.write(RXB_MASK_OFS, 8'h00);
    clk_en = 1'b1;
    rd(RXB_MASK_OFS, 8'h7f, "write while frozen");
    host.write(RXB_CSB_OFS, 8'h00);
    host.write(RXB_UBC_OFS, 8'h00);
  endtask

  task automatic err_hit(input int i, input logic on);
    host.write(RXB_MASK_OFS, on ? 8'h01 << i : 8'h00);
    @(negedge clk);
    err_event = 7'h01 << i;
    @(negedge clk);
    err_event = 7'h00;
    chk({3'h0, shm, irq, hreq, err_out}, {3'h0, 2'b10, on, on && i < 5, on},
        "error outputs");
    rd(RXB_ERR_OFS, on ? 8'h01 << i : 8'h00, "error register");
    @(negedge clk);
    chk({7'h0, err_out}, 8'h00, "error pin after read");
  endtask

  task automatic t_window();
    int n;
    host.write(RXB_CSB_OFS, 8'h01);
    rd(7'h22, 8'ha2, "status window data");
    chk({last_user, last_chan_b, 1'b0, last_ofs}, 8'h42, "status window channel B");
    host.write(RXB_CSB_OFS, 8'h20);
    n = win_cnt + wr_cnt;
    rd(7'h25, 8'h00, "user window outside block mode");
    host.write(7'h26, 8'h11);
    @(negedge clk);
    chk(8'(win_cnt + wr_cnt - n), 8'h00, "no buffer strobe");
    host.write(RXB_UBC_OFS, 8'h04);
    rd(7'h37, 8'hb7, "user window data");
    chk({last_user, last_chan_b, 1'b0, last_ofs}, 8'h97, "user window strobes");
    n = wr_cnt;
    host.write(7'h30, 8'h5a);
    @(negedge clk);
    chk(8'(wr_cnt - n), 8'h01, "window write strobe");
    chk(last_wd, 8'h5a, "window write data");
    host.write(RXB_CSB_OFS, 8'h22);
    rd(7'h20, 8'ha0, "two byte first");
    chk({7'h0, last_chan_b}, 8'h00, "two byte starts at A");
    rd(7'h21, 8'ha1, "two byte second");
    chk({7'h0, last_chan_b}, 8'h01, "two byte then B");
  endtask

  task automatic t_chan(input logic [7:0] csb, input logic [7:0] exp_cs, input logic exp_e);
    host.write(RXB_CSB_OFS, csb);
    repeat (2) @(negedge clk);
    chk(rx_cs, exp_cs, "received status channel");
    chk({7'h0, emphasis}, {7'h0, exp_e}, "emphasis channel");
  endtask

  task automatic xfer(input logic [7:0] csb, input logic [7:0] ubc, input logic [4:0] b,
                      input logic [3:0] exp);
    host.write(RXB_CSB_OFS, csb);
    host.write(RXB_UBC_OFS, ubc);
    @(negedge clk);
    xreq = 4'hf;
    byte_i = b;
    @(negedge clk);
    xreq = 4'h0;
    chk({4'h0, go}, {4'h0, exp}, "transfer permissions");
  endtask

  // Pin level is set first so the synchroniser has it before the clock edge
  task automatic olr_edge(input logic pin, input logic exp);
    int n;
    n = stb_cnt;
    upin_drv = pin;
    repeat (3) @(negedge clk);
    olr = ~olr;
    for (int i = 0; i < 10 && stb_cnt == n; i++) @(negedge clk);
    chk({6'h0, stb_cnt != n, last_tx}, {6'h0, 1'b1, exp}, "transmitted user bit");
  endtask

  task automatic ilr_edge(input logic b);
    rx_ubit = b;
    @(negedge clk);
    ilr = ~ilr;
    for (int i = 0; i < 10 && upin_o !== b; i++) @(negedge clk);
    chk({6'h0, upin_oe, upin}, {6'h0, 1'b1, b}, "user pin output");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #100us;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    t_regs();
    for (int i = 0; i < 7; i++) begin
      err_hit(i, 1'b0);
      err_hit(i, 1'b1);
    end
    t_window();
    t_chan(8'h00, 8'h3c, 1'b1);
    t_chan(8'h01, 8'hc3, 1'b0);
    xfer(8'h00, 8'h04, 5'd0, 4'b1111);
    xfer(8'h10, 8'h04, 5'd4, 4'b0111);
    xfer(8'h10, 8'h04, 5'd5, 4'b1111);
    xfer(8'h08, 8'h04, 5'd9, 4'b0111);
    xfer(8'h04, 8'h04, 5'd9, 4'b1011);
    xfer(8'h00, 8'h06, 5'd9, 4'b1101);
    xfer(8'h00, 8'h05, 5'd9, 4'b1110);
    xfer(8'h00, 8'h0f, 5'd9, 4'b1111);
    chk({7'h0, upin_oe}, 8'h00, "user pin is input");
    olr_edge(1'b1, 1'b1);
    olr_edge(1'b0, 1'b0);
    host.write(RXB_UBC_OFS, 8'h00);
    olr_edge(1'b1, 1'b0);
    host.write(RXB_UBC_OFS, 8'h08);
    olr_edge(1'b1, 1'b1);
    host.write(RXB_UBC_OFS, 8'h1c);
    // Buffer bit differs from both the pin and the zeros source
    ubuf_bit = 1'b1;
    olr_edge(1'b1, 1'b1);
    ilr_edge(1'b1);
    ilr_edge(1'b0);
    conclude();
  end
endmodule
`default_nettype wire

// File: bench/rxb_host.sv
// Host microcontroller model that issues register requests on the control port
`default_nettype none
module rxb_host (
  // Clock
  input  wire logic              clk,
  // Control port
  output var  rxb_pkg::rxb_req_t req,
  input  wire logic [7:0]        rdata,
  input  wire logic              rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  import rxb_pkg::*;

  initial req = '0;

  // Requests change on the falling edge so the taking edge sees them settled
  task automatic write(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
  endtask

  // Plain reads answer by the first falling edge after the take, window reads one later;
  // the valid pulse stands one cycle only, so look before waiting
  task automatic read(input logic [6:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rvalid === 1'b1) begin
        ok = 1'b1;
        d = rdata;
      end else begin
        @(negedge clk);
      end
    end
  endtask
endmodule
`default_nettype wire

// File: design/rxb_ctrl.sv
// Receiver error mask and data buffer control registers on the control port
`default_nettype none
module rxb_ctrl (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  // Control port register access
  input  wire rxb_pkg::rxb_req_t reg_req,
  output var  logic [7:0]       reg_rdata,
  output var  logic             reg_rvalid,
  // Receiver error sources and audio hold
  input  wire logic [6:0]       err_event,
  input  wire logic [1:0]       hold_mode,
  output var  logic             receiver_error_out,
  output var  logic             err_irq,
  output var  logic             sample_hold_req,
  output var  logic [1:0]       sample_hold_mode,
  // Per-channel received information
  input  wire logic             emphasis_a,
  input  wire logic             emphasis_b,
  input  wire logic [7:0]       chan_status_a,
  input  wire logic [7:0]       chan_status_b,
  output var  logic             emphasis_pin,
  output var  logic [7:0]       rx_chan_status,
  // Buffer settings
  output var  logic             buffer_window_select,
  output var  logic             first_bytes_protect,
  output var  logic             buffer_access_width,
  output var  logic             channel_pick,
  output var  logic             user_pin_direction,
  output var  rxb_pkg::rxb_mgr_t user_bit_manager_mode,
  // Buffer transfers
  input  wire logic             cs_dte_req,
  input  wire logic [4:0]       cs_dte_byte,
  input  wire logic             cs_eft_req,
  input  wire logic             ub_dte_req,
  input  wire logic             ub_eft_req,
  output var  logic             cs_dte_go,
  output var  logic             cs_eft_go,
  output var  logic             ub_dte_go,
  output var  logic             ub_eft_go,
  // Buffer window access
  input  wire logic [7:0]       buf_rdata,
  output var  logic             win_rd,
  output var  logic             win_wr,
  output var  logic [4:0]       win_ofs,
  output var  logic [7:0]       win_wdata,
  output var  logic             win_user,
  output var  logic             win_chan_b,
  // User bit pin and frame clocks
  input  wire logic             user_pin_i,
  output var  logic             user_pin_o,
  output var  logic             user_pin_oe,
  input  wire logic             output_side_lr_clock,
  input  wire logic             input_side_lr_clock,
  input  wire logic             rx_user_bit,
  input  wire logic             ubuf_tx_bit,
  output var  logic             tx_user_bit,
  output var  logic             tx_user_strobe
);
  import rxb_pkg::*;

  function automatic logic in_window(input logic [6:0] a);
    in_window = (a >= RXB_WIN_LO) && (a <= RXB_WIN_HI);
  endfunction

  rxb_st_t    st_q;
  rxb_st_t    st_d;
  logic       rd_clr;
  logic [6:0] err_q;
  logic       pin_q;
  logic       irq_q;
  logic       hold_q;
  logic [1:0] hmode_q;
  rxb_mgr_t   mode;
  logic       win_ok;
  logic       olr_edge;
  logic       ilr_edge;
  logic [6:0] win_idx;

  assign mode = rxb_mgr_t'(st_q.ubc[RXB_MGR_HI:RXB_MGR_LO]);
  // User data is only reachable through the window in block mode
  assign win_ok = !st_q.csb[RXB_WINSEL_BIT] || (mode == RXB_MGR_BLOCK);
  assign rd_clr = reg_req.rd && (reg_req.addr == RXB_ERR_OFS);
  assign olr_edge = st_q.olr_s[1] ^ st_q.olr_s[2];
  assign ilr_edge = st_q.ilr_s[1] ^ st_q.ilr_s[2];
  assign win_idx = reg_req.addr - RXB_WIN_LO;

  rxb_err_unit u_err (
    .clk       (clk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .mask      (st_q.mask[6:0]),
    .rd_clr    (rd_clr),
    .hold_mode (hold_mode),
    .err_event (err_event),
    .err_q     (err_q),
    .pin_q     (pin_q),
    .irq_q     (irq_q),
    .hold_q    (hold_q),
    .hmode_q   (hmode_q)
  );

  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    st_d.win_rd = 1'b0;
    st_d.win_wr = 1'b0;
    st_d.tx_stb = 1'b0;
    // Window read data returns one cycle after the buffer strobe
    if (st_q.win_rd) begin
      st_d.rdata = buf_rdata;
      st_d.rvalid = 1'b1;
    end
    if (reg_req.wr) begin
      case (reg_req.addr)
        RXB_MASK_OFS: st_d.mask = reg_req.wdata & RXB_MASK_WR;
        RXB_CSB_OFS:  st_d.csb = reg_req.wdata & RXB_CSB_WR;
        RXB_UBC_OFS:  st_d.ubc = reg_req.wdata & RXB_UBC_WR;
        default: ;
      endcase
    end
    if (reg_req.rd && !in_window(reg_req.addr)) begin
      st_d.rvalid = 1'b1;
      case (reg_req.addr)
        RXB_ERR_OFS:  st_d.rdata = {1'b0, err_q};
        RXB_MASK_OFS: st_d.rdata = st_q.mask;
        RXB_CSB_OFS:  st_d.rdata = st_q.csb;
        RXB_UBC_OFS:  st_d.rdata = st_q.ubc;
        default:      st_d.rdata = 8'h00;
      endcase
    end else if (reg_req.rd && !win_ok) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = 8'h00;
    end
    if ((reg_req.rd || reg_req.wr) && in_window(reg_req.addr) && win_ok) begin
      st_d.win_rd = reg_req.rd;
      st_d.win_wr = reg_req.wr;
      st_d.win_ofs = win_idx[4:0];
      st_d.win_wdata = reg_req.wdata;
      st_d.win_user = st_q.csb[RXB_WINSEL_BIT];
      // One-byte mode follows the channel pick, two-byte mode alternates A then B
      if (st_q.csb[RXB_WIDTH_BIT]) begin
        st_d.win_chan_b = st_q.pair_b;
        st_d.pair_b = !st_q.pair_b;
      end else begin
        st_d.win_chan_b = st_q.csb[RXB_PICK_BIT];
        st_d.pair_b = 1'b0;
      end
    end
    st_d.emphasis = st_q.csb[RXB_PICK_BIT] ? emphasis_b : emphasis_a;
    st_d.chan_status = st_q.csb[RXB_PICK_BIT] ? chan_status_b : chan_status_a;
    st_d.go[0] = cs_dte_req && !st_q.csb[RXB_CS_DE_INH_BIT]
                 && !(st_q.csb[RXB_KEEP_BIT] && (cs_dte_byte < RXB_PROTECT_BYTES));
    st_d.go[1] = cs_eft_req && !st_q.csb[RXB_CS_EF_INH_BIT];
    st_d.go[2] = ub_dte_req
                 && !((mode == RXB_MGR_BLOCK) && st_q.ubc[RXB_UB_DE_INH_BIT]);
    st_d.go[3] = ub_eft_req
                 && !((mode == RXB_MGR_BLOCK) && st_q.ubc[RXB_UB_EF_INH_BIT]);
    // Pins cross in through two stages; the third stage only serves edge detection
    st_d.olr_s = {st_q.olr_s[1:0], output_side_lr_clock};
    st_d.ilr_s = {st_q.ilr_s[1:0], input_side_lr_clock};
    st_d.upin_s = {st_q.upin_s[0], user_pin_i};
    st_d.upin_oe = st_q.ubc[RXB_UDIR_BIT];
    if (st_q.ubc[RXB_UDIR_BIT] && ilr_edge) begin
      st_d.upin_o = rx_user_bit;
    end
    if (olr_edge) begin
      st_d.tx_stb = 1'b1;
      if (mode == RXB_MGR_ZEROS) begin
        st_d.tx_bit = 1'b0;
      end else if (st_q.ubc[RXB_UDIR_BIT]) begin
        st_d.tx_bit = ubuf_tx_bit;
      end else begin
        st_d.tx_bit = st_q.upin_s[1];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.mask <= RXB_MASK_RST;
      st_q.csb <= RXB_CSB_RST;
      st_q.ubc <= RXB_UBC_RST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign receiver_error_out = pin_q;
  assign err_irq = irq_q;
  assign sample_hold_req = hold_q;
  assign sample_hold_mode = hmode_q;
  assign emphasis_pin = st_q.emphasis;
  assign rx_chan_status = st_q.chan_status;
  assign buffer_window_select = st_q.csb[RXB_WINSEL_BIT];
  assign first_bytes_protect = st_q.csb[RXB_KEEP_BIT];
  assign buffer_access_width = st_q.csb[RXB_WIDTH_BIT];
  assign channel_pick = st_q.csb[RXB_PICK_BIT];
  assign user_pin_direction = st_q.ubc[RXB_UDIR_BIT];
  assign user_bit_manager_mode = mode;
  assign cs_dte_go = st_q.go[0];
  assign cs_eft_go = st_q.go[1];
  assign ub_dte_go = st_q.go[2];
  assign ub_eft_go = st_q.go[3];
  assign win_rd = st_q.win_rd;
  assign win_wr = st_q.win_wr;
  assign win_ofs = st_q.win_ofs;
  assign win_wdata = st_q.win_wdata;
  assign win_user = st_q.win_user;
  assign win_chan_b = st_q.win_chan_b;
  assign user_pin_o = st_q.upin_o;
  assign user_pin_oe = st_q.upin_oe;
  assign tx_user_bit = st_q.tx_bit;
  assign tx_user_strobe = st_q.tx_stb;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_mask_top;
    st_q.mask[7] == 1'b0;
  endproperty
  a_mask_top: assert property (p_mask_top) else $error("mask bit 7 set");

  property p_upper_zero;
    reg_rvalid && $past(reg_req.addr) == RXB_UBC_OFS && $past(clk_en)
      |-> reg_rdata[7:5] == 3'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("reserved bits read one");

  property p_protect;
    clk_en && cs_dte_req && first_bytes_protect && cs_dte_byte < RXB_PROTECT_BYTES
      |=> !cs_dte_go;
  endproperty
  a_protect: assert property (p_protect) else $error("protected byte overwritten");

  property p_cs_eft;
    clk_en && cs_eft_req |=> cs_eft_go == !$past(st_q.csb[RXB_CS_EF_INH_BIT]);
  endproperty
  a_cs_eft: assert property (p_cs_eft) else $error("status E-F inhibit wrong");

  property p_ud_dte;
    clk_en && ub_dte_req
      |=> ub_dte_go == !($past(mode) == RXB_MGR_BLOCK && $past(st_q.ubc[RXB_UB_DE_INH_BIT]));
  endproperty
  a_ud_dte: assert property (p_ud_dte) else $error("user D-E inhibit wrong");

  property p_ud_eft;
    clk_en && ub_eft_req
      |=> ub_eft_go == !($past(mode) == RXB_MGR_BLOCK && $past(st_q.ubc[RXB_UB_EF_INH_BIT]));
  endproperty
  a_ud_eft: assert property (p_ud_eft) else $error("user E-F inhibit wrong");

  property p_emphasis_pin;
    clk_en |=> emphasis_pin == $past(channel_pick ? emphasis_b : emphasis_a);
  endproperty
  a_emphasis_pin: assert property (p_emphasis_pin) else $error("emphasis pin wrong channel");

  property p_zeros;
    tx_user_strobe && $past(mode) == RXB_MGR_ZEROS |-> !tx_user_bit;
  endproperty
  a_zeros: assert property (p_zeros) else $error("zeros mode sent a one");

  property p_pin_dir;
    clk_en |=> user_pin_oe == $past(user_pin_direction);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("user pin direction wrong");

  property p_win_sel;
    clk_en && reg_req.rd && in_window(reg_req.addr) && win_ok
      |=> win_rd && win_user == $past(buffer_window_select) ##1 reg_rvalid;
  endproperty
  a_win_sel: assert property (p_win_sel) else $error("window access wrong");

  c_win_user: cover property (win_rd && win_user);
  c_pin_out: cover property (user_pin_oe && tx_user_strobe);
  c_protect: cover property (clk_en && cs_dte_req && first_bytes_protect);
endmodule
`default_nettype wire

// File: design/rxb_err_unit.sv
// Error register with mask gating, error pin, interrupt and hold pulses
`default_nettype none
module rxb_err_unit (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  // Control
  input  wire logic [6:0] mask,
  input  wire logic       rd_clr,
  input  wire logic [1:0] hold_mode,
  // Error sources
  input  wire logic [6:0] err_event,
  // Results
  output var  logic [6:0] err_q,
  output var  logic       pin_q,
  output var  logic       irq_q,
  output var  logic       hold_q,
  output var  logic [1:0] hmode_q
);
  import rxb_pkg::*;

  rxb_err_st_t st_q;
  rxb_err_st_t st_d;
  logic [6:0]  hit;

  always_comb begin
    hit = err_event & mask;
    st_d = st_q;
    // A hit in the clearing read cycle survives the clear
    st_d.err = (rd_clr ? 7'h00 : st_q.err) | hit;
    st_d.pin = |st_d.err;
    st_d.irq = |hit;
    st_d.hold = |(hit & ~RXB_CRC_BITS);
    st_d.hmode = hold_mode;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign err_q = st_q.err;
  assign pin_q = st_q.pin;
  assign irq_q = st_q.irq;
  assign hold_q = st_q.hold;
  assign hmode_q = st_q.hmode;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_unmasked_rec;
    clk_en && |(err_event & mask) |=> (err_q & $past(err_event & mask)) == $past(err_event & mask);
  endproperty
  a_unmasked_rec: assert property (p_unmasked_rec) else $error("unmasked error lost");

  property p_masked_quiet;
    clk_en |=> (err_q & ~$past(mask) & ~$past(err_q)) == 7'h00;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked error recorded");

  property p_crc_no_hold;
    clk_en && ((err_event & mask & ~RXB_CRC_BITS) == 7'h00) |=> !hold_q;
  endproperty
  a_crc_no_hold: assert property (p_crc_no_hold) else $error("CRC error held audio");

  property p_pin;
    pin_q == (|err_q);
  endproperty
  a_pin: assert property (p_pin) else $error("error pin disagrees with register");

  c_crc_only: cover property (clk_en && err_event[RXB_SUBCODE_CRC_BIT] && mask[RXB_SUBCODE_CRC_BIT]);
  c_clear_set: cover property (clk_en && rd_clr && |(err_event & mask));
endmodule
`default_nettype wire

// File: design/rxb_pkg.sv
// Shared constants and types for the receiver error mask and buffer control block
`default_nettype none
package rxb_pkg;
  // Register offsets on the control port
  localparam logic [6:0] RXB_ERR_OFS  = 7'h10;
  localparam logic [6:0] RXB_MASK_OFS = 7'h11;
  localparam logic [6:0] RXB_CSB_OFS  = 7'h12;
  localparam logic [6:0] RXB_UBC_OFS  = 7'h13;
  localparam logic [6:0] RXB_WIN_LO   = 7'h20;
  localparam logic [6:0] RXB_WIN_HI   = 7'h37;
  // Reset values and writable bits
  localparam logic [7:0] RXB_MASK_RST = 8'h00;
  localparam logic [7:0] RXB_CSB_RST  = 8'h00;
  localparam logic [7:0] RXB_UBC_RST  = 8'h00;
  localparam logic [7:0] RXB_MASK_WR  = 8'h7f;
  localparam logic [7:0] RXB_CSB_WR   = 8'h3f;
  localparam logic [7:0] RXB_UBC_WR   = 8'h1f;
  // Error bit positions; the two CRC errors never touch audio
  localparam int unsigned RXB_SUBCODE_CRC_BIT = 6;
  localparam int unsigned RXB_STATUS_CRC_BIT  = 5;
  localparam logic [6:0]  RXB_CRC_BITS        = 7'h60;
  // Channel status buffer control fields
  localparam int unsigned RXB_PICK_BIT      = 0;
  localparam int unsigned RXB_WIDTH_BIT     = 1;
  localparam int unsigned RXB_CS_EF_INH_BIT = 2;
  localparam int unsigned RXB_CS_DE_INH_BIT = 3;
  localparam int unsigned RXB_KEEP_BIT      = 4;
  localparam int unsigned RXB_WINSEL_BIT    = 5;
  // User buffer control fields
  localparam int unsigned RXB_UB_EF_INH_BIT = 0;
  localparam int unsigned RXB_UB_DE_INH_BIT = 1;
  localparam int unsigned RXB_MGR_LO        = 2;
  localparam int unsigned RXB_MGR_HI        = 3;
  localparam int unsigned RXB_UDIR_BIT      = 4;
  // Leading channel status bytes kept by the protect bit
  localparam logic [4:0] RXB_PROTECT_BYTES = 5'd5;

  typedef enum logic [1:0] {
    RXB_MGR_ZEROS = 2'b00,
    RXB_MGR_BLOCK = 2'b01,
    RXB_MGR_RSVD  = 2'b10,
    RXB_MGR_CONSB = 2'b11
  } rxb_mgr_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } rxb_req_t;

  typedef struct packed {
    logic [6:0] err;
    logic       pin;
    logic       irq;
    logic       hold;
    logic [1:0] hmode;
  } rxb_err_st_t;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] csb;
    logic [7:0] ubc;
    logic [7:0] rdata;
    logic       rvalid;
    logic       win_rd;
    logic       win_wr;
    logic [4:0] win_ofs;
    logic [7:0] win_wdata;
    logic       win_user;
    logic       win_chan_b;
    logic       pair_b;
    logic       emphasis;
    logic [7:0] chan_status;
    logic [3:0] go;
    logic [2:0] olr_s;
    logic [2:0] ilr_s;
    logic [1:0] upin_s;
    logic       upin_o;
    logic       upin_oe;
    logic       tx_bit;
    logic       tx_stb;
  } rxb_st_t;
endpackage
`default_nettype wire
